/* core/pdc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: Bus error sets flag; control read clears.
// RL2: Count reaching zero sets flag; read clears.
// RL3: Transfers only while enable set; clear stops.
// RL4: Direction 0 port-to-memory, 1 memory-to-port.
// RL5: Pointer: four byte registers from 8C00, MSB first.
// RL6: Count: four byte registers from 8C08, MSB first.
// RL7: Byte registers use low byte; upper unused.
// RL8: Leftover data readable as high, low halves.
// RL9: Legacy disk first, serial next, disk last.
// RL10: Interrupt request is an active-low level.
// RL11: Each byte steps pointer, count; stop at zero.
// RL12: Request on either flag; drop after control read.
module pdc_channel (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Processor register port.
    input  wire logic        regSelect,
    input  wire logic        regWrite,
    input  wire logic [15:0] regAddress,
    input  wire logic [15:0] regWriteData,
    output logic      [15:0] regReadData,
    output logic             regReadValid,
    // Memory bus master side.
    input  wire logic        higherRequest,
    output logic             busRequest,
    input  wire logic        busGrant,
    output logic      [31:0] memAddress,
    output logic             memWrite,
    output logic      [7:0]  memWriteData,
    input  wire logic [7:0]  memReadData,
    input  wire logic        memAck,
    input  wire logic        memError,
    // Peripheral port side.
    input  wire logic        portInValid,
    input  wire logic [7:0]  portInData,
    output logic             portInTake,
    output logic             portOutValid,
    output logic      [7:0]  portOutData,
    input  wire logic        portOutReady,
    // Request line to the peripheral input pin.
    output logic             irqLine_n
);

    pdc_pkg::pdc_state_e state;

    logic        enable;
    logic        direction;
    logic        busErrorFlag;
    logic        countZeroFlag;
    logic [31:0] pointer;
    logic [31:0] count;
    logic [31:0] leftover;
    logic [3:0]  ptrLaneWrite;
    logic [3:0]  cntLaneWrite;
    logic        stepByte;
    logic        controlWrite;
    logic        controlRead;
    logic        readStrobe;
    logic        setBusError;
    logic        setCountZero;
    logic        next_busErrorFlag;
    logic        next_countZeroFlag;
    logic [15:0] next_readData;

    // Register port strobes.
    assign readStrobe   = regSelect && !regWrite;
    assign controlWrite = regSelect && regWrite && (regAddress == pdc_pkg::CONTROL_OFS);
    assign controlRead  = readStrobe && (regAddress == pdc_pkg::CONTROL_OFS);

    // Byte-lane decode for pointer and count; lane 3 sits at the lowest offset.
    // Only the low byte of a write is used; the upper byte of each register is unused.
    always_comb begin
        ptrLaneWrite = 4'h0;
        cntLaneWrite = 4'h0;
        if (regSelect && regWrite) begin
            case (regAddress)
                pdc_pkg::PTR_BYTE3_OFS: ptrLaneWrite = 4'b1000; // RL5
                pdc_pkg::PTR_BYTE2_OFS: ptrLaneWrite = 4'b0100; // RL5
                pdc_pkg::PTR_BYTE1_OFS: ptrLaneWrite = 4'b0010; // RL5
                pdc_pkg::PTR_BYTE0_OFS: ptrLaneWrite = 4'b0001; // RL5
                pdc_pkg::CNT_BYTE3_OFS: cntLaneWrite = 4'b1000; // RL6
                pdc_pkg::CNT_BYTE2_OFS: cntLaneWrite = 4'b0100; // RL6
                pdc_pkg::CNT_BYTE1_OFS: cntLaneWrite = 4'b0010; // RL6
                pdc_pkg::CNT_BYTE0_OFS: cntLaneWrite = 4'b0001; // RL6
                default: begin
                    ptrLaneWrite = 4'h0;
                    cntLaneWrite = 4'h0;
                end
            endcase
        end
    end

    // One byte moved: the memory cycle completed without error.
    // An errored cycle moves nothing, so pointer and count keep pointing at the failed byte.
    assign stepByte = (state == pdc_pkg::PDC_MEM) && busRequest && busGrant && memAck && !memError; // RL11

    // Memory pointer counts up per byte.
    pdc_byte_word #(
        .STEP_DOWN (1'b0)
    ) pointerWord (
        .clock     (clock),
        .reset_n   (reset_n),
        .laneWrite (ptrLaneWrite),
        .laneData  (regWriteData[7:0]), // RL7
        .step      (stepByte),
        .value     (pointer)
    );

    // Byte count counts down per byte.
    pdc_byte_word #(
        .STEP_DOWN (1'b1)
    ) countWord (
        .clock     (clock),
        .reset_n   (reset_n),
        .laneWrite (cntLaneWrite),
        .laneData  (regWriteData[7:0]), // RL7
        .step      (stepByte),
        .value     (count)
    );

    // Enable and direction are software controlled; a bus error also drops enable.
    // Dropping enable on an error keeps a faulted channel from retrying on its own.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable    <= 1'b0;
            direction <= 1'b0;
        end else if (controlWrite) begin
            enable    <= regWriteData[pdc_pkg::CTRL_ENABLE_BIT]; // RL3
            direction <= regWriteData[pdc_pkg::CTRL_DIR_BIT]; // RL4
        end else if (setBusError) begin
            enable <= 1'b0;
        end
    end

    // Flag events from the memory cycle.
    assign setBusError  = (state == pdc_pkg::PDC_MEM) && busRequest && busGrant && memError;
    assign setCountZero = stepByte && (count == 32'h0000_0001);

    // Sticky flags: a control read clears them, but a new event in that cycle wins.
    // Letting the event win means software never loses a flag it has not yet seen.
    always_comb begin
        next_busErrorFlag  = busErrorFlag;
        next_countZeroFlag = countZeroFlag;
        if (controlRead) begin
            next_busErrorFlag  = 1'b0; // RL1
            next_countZeroFlag = 1'b0; // RL2
        end
        if (setBusError) begin
            next_busErrorFlag = 1'b1; // RL1
        end
        if (setCountZero) begin
            next_countZeroFlag = 1'b1; // RL2
        end
    end

    // Flag storage and the active-low request level that follows them.
    // The level is built from the next flag values so it moves on the same edge as the flags.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busErrorFlag  <= 1'b0;
            countZeroFlag <= 1'b0;
            irqLine_n     <= 1'b1;
        end else begin
            busErrorFlag  <= next_busErrorFlag;
            countZeroFlag <= next_countZeroFlag;
            irqLine_n     <= !(next_busErrorFlag || next_countZeroFlag); // RL10 RL12
        end
    end

    // Read data multiplexer; unused upper bytes and unmapped offsets read zero.
    // Status bits come straight from the flags; the clearing happens in the flag logic.
    always_comb begin
        next_readData = pdc_pkg::READ_ZERO;
        case (regAddress)
            pdc_pkg::PTR_BYTE3_OFS: next_readData = {8'h00, pointer[31:24]}; // RL5 RL7
            pdc_pkg::PTR_BYTE2_OFS: next_readData = {8'h00, pointer[23:16]};
            pdc_pkg::PTR_BYTE1_OFS: next_readData = {8'h00, pointer[15:8]};
            pdc_pkg::PTR_BYTE0_OFS: next_readData = {8'h00, pointer[7:0]};
            pdc_pkg::CNT_BYTE3_OFS: next_readData = {8'h00, count[31:24]}; // RL6 RL7
            pdc_pkg::CNT_BYTE2_OFS: next_readData = {8'h00, count[23:16]};
            pdc_pkg::CNT_BYTE1_OFS: next_readData = {8'h00, count[15:8]};
            pdc_pkg::CNT_BYTE0_OFS: next_readData = {8'h00, count[7:0]};
            pdc_pkg::LEFT_HIGH_OFS: next_readData = leftover[31:16]; // RL8
            pdc_pkg::LEFT_LOW_OFS:  next_readData = leftover[15:0]; // RL8
            pdc_pkg::CONTROL_OFS: begin
                next_readData[pdc_pkg::CTRL_BUSERR_BIT] = busErrorFlag;
                next_readData[pdc_pkg::CTRL_ZERO_BIT]   = countZeroFlag;
                next_readData[pdc_pkg::CTRL_ENABLE_BIT] = enable;
                next_readData[pdc_pkg::CTRL_DIR_BIT]    = direction;
            end
            default: next_readData = pdc_pkg::READ_ZERO;
        endcase
    end

    // Read answer one cycle after the strobe.
    // The data word holds between reads so a slow reader may pick it up late.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            regReadData  <= pdc_pkg::READ_ZERO;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= readStrobe;
            if (readStrobe) begin
                regReadData <= next_readData;
            end
        end
    end

    // Leftover data: bytes taken from the port shift in; a memory write empties the newest.
    // After a stop the register shows what was taken from the port but never reached memory.
    // Software can recover those bytes through the two read-only halves.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            leftover <= pdc_pkg::WORD_RESET;
        end else if (state == pdc_pkg::PDC_PORT_IN && portInValid && !portInTake && enable) begin
            leftover <= {leftover[23:0], portInData}; // RL8
        end else if (stepByte && !direction) begin
            leftover <= {leftover[31:8], pdc_pkg::BYTE_RESET}; // RL8
        end
    end

    // Channel sequencer with registered outputs toward memory and port.
    // Address and write strobe are loaded while the request is still low, so they stand
    // before the grant. A request not yet granted is withdrawn when a higher channel asks
    // or software disables; once granted the cycle always runs to its answer.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state        <= pdc_pkg::PDC_IDLE;
            busRequest   <= 1'b0;
            memAddress   <= pdc_pkg::WORD_RESET;
            memWrite     <= 1'b0;
            memWriteData <= pdc_pkg::BYTE_RESET;
            portInTake   <= 1'b0;
            portOutValid <= 1'b0;
            portOutData  <= pdc_pkg::BYTE_RESET;
        end else begin
            portInTake <= 1'b0;
            case (state)
                pdc_pkg::PDC_IDLE: begin
                    if (enable && !controlWrite && count != 32'h0000_0000) begin // RL3 RL11
                        if (direction) begin
                            state <= pdc_pkg::PDC_MEM; // RL4
                        end else begin
                            state <= pdc_pkg::PDC_PORT_IN; // RL4
                        end
                    end
                end
                pdc_pkg::PDC_PORT_IN: begin
                    if (!enable) begin
                        state <= pdc_pkg::PDC_IDLE; // RL3
                    end else if (portInValid && !portInTake) begin
                        portInTake   <= 1'b1;
                        memWriteData <= portInData;
                        state        <= pdc_pkg::PDC_MEM;
                    end
                end
                pdc_pkg::PDC_MEM: begin
                    memAddress <= pointer;
                    memWrite   <= !direction; // RL4
                    if (!busRequest) begin
                        if (!enable) begin
                            state <= pdc_pkg::PDC_IDLE; // RL3
                        end else if (!higherRequest) begin
                            busRequest <= 1'b1; // RL9
                        end
                    end else if (busGrant && (memAck || memError)) begin
                        busRequest <= 1'b0;
                        memWrite   <= 1'b0;
                        if (memError) begin
                            state <= pdc_pkg::PDC_IDLE; // RL1
                        end else if (direction) begin
                            portOutData  <= memReadData;
                            portOutValid <= 1'b1;
                            state        <= pdc_pkg::PDC_PORT_OUT;
                        end else begin
                            state <= pdc_pkg::PDC_IDLE; // RL11
                        end
                    end else if (!busGrant && (!enable || higherRequest)) begin
                        busRequest <= 1'b0; // RL3 RL9
                    end
                end
                pdc_pkg::PDC_PORT_OUT: begin
                    if (portOutReady) begin
                        portOutValid <= 1'b0;
                        state        <= pdc_pkg::PDC_IDLE;
                    end
                end
                default: begin
                    state        <= pdc_pkg::PDC_IDLE;
                    busRequest   <= 1'b0;
                    portOutValid <= 1'b0;
                end
            endcase
        end
    end

endmodule // pdc_channel
`default_nettype wire

/* core/pdc_pkg.sv */
`default_nettype none
// Shared constants for the peripheral transfer engine channel.
package pdc_pkg;

    // Register offsets on the processor register port (byte addresses).
    localparam logic [15:0] PTR_BYTE3_OFS   = 16'h8C00;
    localparam logic [15:0] PTR_BYTE2_OFS   = 16'h8C02;
    localparam logic [15:0] PTR_BYTE1_OFS   = 16'h8C04;
    localparam logic [15:0] PTR_BYTE0_OFS   = 16'h8C06;
    localparam logic [15:0] CNT_BYTE3_OFS   = 16'h8C08;
    localparam logic [15:0] CNT_BYTE2_OFS   = 16'h8C0A;
    localparam logic [15:0] CNT_BYTE1_OFS   = 16'h8C0C;
    localparam logic [15:0] CNT_BYTE0_OFS   = 16'h8C0E;
    localparam logic [15:0] LEFT_HIGH_OFS   = 16'h8C10;
    localparam logic [15:0] LEFT_LOW_OFS    = 16'h8C12;
    localparam logic [15:0] CONTROL_OFS     = 16'h8C14;

    // Control register field positions.
    localparam int CTRL_DIR_BIT    = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CTRL_ZERO_BIT   = 6;
    localparam int CTRL_BUSERR_BIT = 7;

    // Reset values.
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
    localparam logic [15:0] READ_ZERO     = 16'h0000;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;

    // Channel sequencer states.
    typedef enum logic [2:0] {
        PDC_IDLE     = 3'b000,
        PDC_PORT_IN  = 3'b001,
        PDC_MEM      = 3'b010,
        PDC_PORT_OUT = 3'b011
    } pdc_state_e;

endpackage
`default_nettype wire

/* core/pdc_byte_word.sv */
`timescale 1ns/1ps
`default_nettype none
// A 32-bit word that software loads one byte lane at a time and that
// hardware steps by one, up or down.
module pdc_byte_word #(
    parameter bit STEP_DOWN = 1'b0
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Software byte-lane load.
    input  wire logic [3:0]  laneWrite,
    input  wire logic [7:0]  laneData,
    // Hardware step.
    input  wire logic        step,
    // Current value.
    output logic      [31:0] value
);

    // Byte lanes load from software; otherwise a step moves the word by one.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            value <= pdc_pkg::WORD_RESET;
        end else if (laneWrite != 4'h0) begin
            for (int i = 0; i < 4; i++) begin
                if (laneWrite[i]) begin
                    value[i*8 +: 8] <= laneData;
                end
            end
        end else if (step) begin
            value <= STEP_DOWN ? value - 32'h0000_0001 : value + 32'h0000_0001;
        end
    end

endmodule // pdc_byte_word
`default_nettype wire

/* verif/pdc_channel_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the channel ports for bus, port and request-line timing.
module pdc_channel_assertions (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        reset_n,
    // Register and memory bus side.
    input wire logic        regSelect,
    input wire logic        regWrite,
    input wire logic [15:0] regAddress,
    input wire logic        regReadValid,
    input wire logic        higherRequest,
    input wire logic        busRequest,
    input wire logic        busGrant,
    input wire logic [31:0] memAddress,
    input wire logic        memAck,
    input wire logic        memError,
    // Peripheral side.
    input wire logic        portInTake,
    input wire logic        portOutValid,
    input wire logic [7:0]  portOutData,
    input wire logic        portOutReady,
    input wire logic        irqLine_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic memDone;
    // A memory cycle ends at the edge that sees an answer while granted.
    assign memDone = busRequest && busGrant && (memAck || memError);
    // Request line, register answers, bus cycles and port handshakes.
    a_error_raises_irq: assert property (memDone && memError |=> !irqLine_n)
        else $error("request line not low after bus error");
    a_error_stops_bus: assert property (memDone && memError |=> !busRequest [*8])
        else $error("bus requested after bus error");
    a_read_answers: assert property (regSelect && !regWrite |=> regReadValid)
        else $error("read not answered");
    a_req_drops: assert property (memDone |=> !busRequest)
        else $error("request kept after memory answer");
    a_grant_holds: assert property (busRequest && busGrant && !memDone |=> busRequest && $stable(memAddress))
        else $error("granted cycle changed");
    a_defers_higher: assert property (!busRequest && higherRequest |=> !busRequest)
        else $error("request raised over higher channel");
    a_ctrl_read_frees: assert property (regSelect && !regWrite && regAddress == pdc_pkg::CONTROL_OFS
        && !busRequest && !busGrant |-> ##[1:2] irqLine_n) else $error("request line kept after control read");
    a_out_holds: assert property (portOutValid && !portOutReady |=> portOutValid && $stable(portOutData))
        else $error("outgoing byte not held");
    a_take_single: assert property (portInTake |=> !portInTake)
        else $error("byte taken twice");
    c_bus_error: cover property (memDone && memError);
    c_byte_out: cover property (portOutValid && portOutReady);
    c_byte_in: cover property (portInTake);
endmodule // pdc_channel_assertions
bind pdc_channel pdc_channel_assertions u_chk (.*);
`default_nettype wire

/* verif/pdc_port_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Peripheral controller model on the far side of the channel.
module pdc_port_partner #(
    parameter logic [7:0] FIRST_IN = 8'h9D
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Bytes offered to the channel.
    output logic            portInValid,
    output logic      [7:0] portInData,
    input  wire logic       portInTake,
    // Bytes taken from the channel.
    input  wire logic       portOutValid,
    input  wire logic [7:0] portOutData,
    output logic            portOutReady,
    // Record of bytes taken.
    output logic      [7:0] gotLast,
    output logic      [3:0] gotCount
);
    logic [7:0] nextIn;
    // Offers bytes in turn, withdrawing for a cycle after each take; a withdrawn bus shows the inverse.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            portInValid <= 1'b0;
            portInData  <= ~FIRST_IN;
            nextIn      <= FIRST_IN;
        end else if (portInTake) begin
            portInValid <= 1'b0;
            portInData  <= ~portInData;
            nextIn      <= nextIn + 8'h01;
        end else begin
            portInValid <= 1'b1;
            portInData  <= nextIn;
        end
    end
    // Accepts on alternate cycles only, so the channel must hold its byte.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            portOutReady <= 1'b0;
            gotLast      <= 8'h00;
            gotCount     <= 4'h0;
        end else begin
            portOutReady <= ~portOutReady;
            if (portOutValid && portOutReady) begin
                gotLast  <= portOutData;
                gotCount <= gotCount + 4'h1;
            end
        end
    end
endmodule // pdc_port_partner
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Drives the channel through its register port against a memory and a peripheral model.
module tb_top;
    logic        clock = 1'b0, reset_n = 1'b0, regSelect = 1'b0, regWrite = 1'b0;
    logic        higherRequest = 1'b0, busGrant = 1'b0, memAck = 1'b0, memError = 1'b0;
    logic [15:0] regAddress = 16'h0000, regWriteData = 16'h0000, regReadData, rd;
    logic [7:0]  memReadData = 8'h00, memWriteData, portInData, portOutData, gotLast;
    logic [7:0]  mem [0:15];
    logic [31:0] memAddress;
    logic [3:0]  gotCount;
    logic        regReadValid, busRequest, memWrite, portInValid, portInTake;
    logic        portOutValid, portOutReady, irqLine_n, errArm = 1'b0, reqSeen = 1'b0;
    int          fails = 0, comparisons = 0;
    pdc_channel uut (.clock, .reset_n, .regSelect, .regWrite, .regAddress, .regWriteData, .regReadData,
        .regReadValid, .higherRequest, .busRequest, .busGrant, .memAddress, .memWrite, .memWriteData,
        .memReadData, .memAck, .memError, .portInValid, .portInData, .portInTake, .portOutValid,
        .portOutData, .portOutReady, .irqLine_n);
    pdc_port_partner u_peer (.clock, .reset_n, .portInValid, .portInData, .portInTake, .portOutValid,
        .portOutData, .portOutReady, .gotLast, .gotCount);
    // Clock generation.
    always #10 clock = ~clock;
    // Memory grants a request, then answers it one cycle later.
    always @(negedge clock) begin
        memAck <= 1'b0;
        memError <= 1'b0;
        if (busRequest && busGrant && !memAck && !memError) begin
            memAck <= !errArm;
            memError <= errArm;
            memReadData <= mem[memAddress[3:0]];
            if (memWrite) mem[memAddress[3:0]] <= memWriteData;
        end
        busGrant <= busRequest && !(memAck || memError);
    end
    // Notes any bus request.
    always @(posedge clock) if (busRequest) reqSeen <= 1'b1;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        @(negedge clock);
        regSelect = 1'b1;
        regWrite = wr;
        regAddress = addr;
        regWriteData = data;
        @(negedge clock);
        regSelect = 1'b0;
        rd = regReadData;
        if (!wr) check("read valid", {15'h0000, regReadValid}, 16'h0001);
    endtask
    task automatic rchk(input string name, input logic [15:0] addr, input logic [15:0] exp);
        access(1'b0, addr, 16'h0000);
        check(name, rd, exp);
    endtask
    task automatic prog(input logic [7:0] p, input logic [7:0] c, input logic [15:0] ctl);
        access(1'b1, pdc_pkg::CONTROL_OFS, 16'h0000);
        for (int i = 0; i < 8; i++) access(1'b1, 16'h8C00 + 16'(2 * i), {8'h00, i == 3 ? p : i == 7 ? c : 8'h00});
        access(1'b1, pdc_pkg::CONTROL_OFS, ctl);
    endtask
    task automatic wait_irq(input logic [3:0] outs);
        for (int n = 0; n < 200 && (irqLine_n !== 1'b0 || gotCount !== outs); n++) @(negedge clock);
        check("request line", {15'h0000, irqLine_n}, 16'h0000);
        check("bytes out", {12'h000, gotCount}, {12'h000, outs});
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake.
    initial begin
        #200_000;
        fails++;
        end_sim;
    end
    // Test sequence.
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
        mem[4] = 8'h5A;
        mem[5] = 8'hC3;
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        for (int i = 0; i < 12; i++) rchk("reset value", 16'h8C00 + 16'(2 * i), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            access(1'b1, 16'h8C00 + 16'(2 * i), {8'hA5, 8'(8'h11 * i)});
            rchk("byte lane", 16'h8C00 + 16'(2 * i), {8'h00, 8'(8'h11 * i)});
        end
        access(1'b1, pdc_pkg::LEFT_HIGH_OFS, 16'hFFFF);
        rchk("leftover", pdc_pkg::LEFT_HIGH_OFS, 16'h0000);
        prog(8'h04, 8'h02, 16'h0003);
        wait_irq(4'h2);
        check("out last", {8'h00, gotLast}, 16'h00C3);
        rchk("pointer", pdc_pkg::PTR_BYTE0_OFS, 16'h0006);
        rchk("count", pdc_pkg::CNT_BYTE0_OFS, 16'h0000);
        access(1'b0, pdc_pkg::CONTROL_OFS, 16'h0000);
        check("zero flag", rd & 16'h00C0, 16'h0040);
        @(negedge clock);
        check("line freed", {15'h0000, irqLine_n}, 16'h0001);
        access(1'b0, pdc_pkg::CONTROL_OFS, 16'h0000);
        check("flag cleared", rd & 16'h00C0, 16'h0000);
        prog(8'h08, 8'h02, 16'h0002);
        wait_irq(4'h2);
        check("mem in 0", {8'h00, mem[8]}, 16'h009D);
        check("mem in 1", {8'h00, mem[9]}, 16'h009E);
        access(1'b0, pdc_pkg::CONTROL_OFS, 16'h0000);
        higherRequest = 1'b1;
        reqSeen = 1'b0;
        prog(8'h04, 8'h01, 16'h0003);
        repeat (20) @(negedge clock);
        check("deferred", {15'h0000, reqSeen}, 16'h0000);
        access(1'b1, pdc_pkg::CONTROL_OFS, 16'h0001);
        higherRequest = 1'b0;
        reqSeen = 1'b0;
        repeat (20) @(negedge clock);
        check("disabled", {15'h0000, reqSeen}, 16'h0000);
        access(1'b1, pdc_pkg::CONTROL_OFS, 16'h0003);
        wait_irq(4'h3);
        check("out byte", {8'h00, gotLast}, 16'h005A);
        access(1'b0, pdc_pkg::CONTROL_OFS, 16'h0000);
        errArm = 1'b1;
        prog(8'h04, 8'h02, 16'h0003);
        wait_irq(4'h3);
        access(1'b0, pdc_pkg::CONTROL_OFS, 16'h0000);
        check("bus error", rd & 16'h00C2, 16'h0080);
        rchk("no step", pdc_pkg::CNT_BYTE0_OFS, 16'h0002);
        rchk("error cleared", pdc_pkg::CONTROL_OFS, 16'h0001);
        errArm = 1'b0;
        // A byte taken from the port but held back from memory shows in the leftover word.
        higherRequest = 1'b1;
        prog(8'h08, 8'h01, 16'h0002);
        repeat (5) @(negedge clock);
        rchk("leftover held", pdc_pkg::LEFT_LOW_OFS, 16'h009F);
        rchk("count held", pdc_pkg::CNT_BYTE0_OFS, 16'h0001);
        access(1'b1, pdc_pkg::CONTROL_OFS, 16'h0000);
        higherRequest = 1'b0;
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
